// File: usi_regs.svh
/*
 * register offsets, field positions, reset values and clock figures
 * of the serial status and interrupt block.
 * assumes: included by bare name from the block's design files.
 */
`ifndef USI_REGS_SVH
`define USI_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define USI_OFS_CHAR_FMT    4'h0
`define USI_OFS_BAUD_SEL    4'h1
`define USI_OFS_MODEM_CTL   4'h2
`define USI_OFS_LINE_STAT   4'h3
`define USI_OFS_MODEM_STAT  4'h4
`define USI_OFS_TX_HOLD     4'h5
`define USI_OFS_RX_BUF      4'h6
`define USI_OFS_IRQ_STAT    4'h7
`define USI_OFS_IRQ_MASK    4'h8

////////////////////////////////////////////////////////////////////////////////
// line status bits, the low six also index the edge latches
`define USI_LS_OVERRUN      0
`define USI_LS_PARITY       1
`define USI_LS_FRAMING      2
`define USI_LS_BREAK        3
`define USI_LS_MODEM        4
`define USI_LS_TXDONE       5
`define USI_LS_TXEMPTY      6
`define USI_LS_RXRDY        7

// modem control bits
`define USI_MC_DTR          0
`define USI_MC_RTS          1
`define USI_MC_MODEM_IRQ_MASK         5
`define USI_MC_GLOBAL_IRQ_ENABLE        6

// character format fields
`define USI_CF_WLEN_LO      0
`define USI_CF_WLEN_HI      1
`define USI_CF_STOP2        2
`define USI_CF_TX_PAR_EN    3
`define USI_CF_TX_PAR_ODD   4
`define USI_CF_RX_PAR_EN    5
`define USI_CF_RX_PAR_ODD   6

////////////////////////////////////////////////////////////////////////////////
// reset values
`define USI_RST_CHAR_FMT    8'h03
`define USI_RST_BAUD_SEL    8'h40
`define USI_RST_MODEM_CTL   8'h00
`define USI_RST_LINE_STAT   8'h60
`define USI_RST_EDGE        6'h20
`define USI_RST_IRQ_MASK    6'h3F
`define USI_EDGE_MODEM_MASK 6'h10

////////////////////////////////////////////////////////////////////////////////
// clock figures in hertz, and the oversample factor
`define USI_CLK_HZ          40000000
`define USI_REF_HZ          2457600
`define USI_OVERSAMPLE      16

`endif

// File: usi_pkg.sv
/*
 * types shared by the serial status and interrupt block.
 * assumes: compiled before the modules that import it.
 */
package usi_pkg;

    typedef logic [7:0] usi_byte_type;

    typedef enum logic [4:0] {
        USI_TX_IDLE  = 5'b0_0001,
        USI_TX_START = 5'b0_0010,
        USI_TX_DATA  = 5'b0_0100,
        USI_TX_PAR   = 5'b0_1000,
        USI_TX_STOP  = 5'b1_0000
    } usi_tx_state_type;

endpackage

// File: usi_tx_shift.sv
/*
 * transmit shift register: start bit, 5 to 8 data bits lsb first,
 * optional parity, then one stop bit time, or two with stop2 set.
 * assumes: bit_tick is a one-cycle pulse per bit time; load only while idle.
 */
`timescale 1ns/1ps
`include "usi_regs.svh"

module usi_tx_shift
    import usi_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         bit_tick,
    input  wire logic         load,
    input  wire usi_byte_type load_data,
    input  wire logic [1:0]   word_len,
    input  wire logic         stop2,
    input  wire logic         par_en,
    input  wire logic         par_odd,
    output logic              sdo,
    output logic              busy
);

    usi_tx_state_type state_q;
    usi_byte_type     shreg_q;
    logic [2:0]       cnt_q;
    logic             par_q;
    logic             lsb_q;

    ////////////////////////////////////////////////////////////////////////////
    // lsb shifted first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= USI_TX_IDLE;
            shreg_q <= 8'h00;
            cnt_q   <= 3'h0;
            par_q   <= 1'b0;
            sdo     <= 1'b1;
            busy    <= 1'b0;
        end else begin
            unique case (state_q)
                USI_TX_IDLE: begin
                    if (load) begin
                        shreg_q <= load_data;
                        par_q   <= par_odd;
                        busy    <= 1'b1;
                        state_q <= USI_TX_START;
                    end
                end
                USI_TX_START: begin
                    if (bit_tick) begin
                        sdo     <= 1'b0;
                        cnt_q   <= {1'b1, word_len};
                        state_q <= USI_TX_DATA;
                    end
                end
                USI_TX_DATA: begin
                    if (bit_tick) begin
                        sdo     <= shreg_q[0];
                        par_q   <= par_q ^ shreg_q[0];
                        shreg_q <= {1'b0, shreg_q[7:1]};
                        cnt_q   <= cnt_q - 3'h1;
                        if (cnt_q == 3'h0) begin
                            state_q <= par_en ? USI_TX_PAR : USI_TX_STOP;
                        end
                    end
                end
                USI_TX_PAR: begin
                    if (bit_tick) begin
                        sdo     <= par_q;
                        state_q <= USI_TX_STOP;
                    end
                end
                USI_TX_STOP: begin
                    if (bit_tick) begin
                        sdo   <= 1'b1;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == {2'b00, stop2}) begin
                            busy    <= 1'b0;
                            state_q <= USI_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // lsb of the character as loaded, kept for the bit-order check
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lsb_q <= 1'b0;
        end else if (load && state_q == USI_TX_IDLE) begin
            lsb_q <= load_data[0];
        end
    end

    lsb_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == USI_TX_DATA && bit_tick && cnt_q == {1'b1, word_len}) |=> sdo == lsb_q)
        else $error("first data bit is not the lsb");

    frame_cov_c: cover property (@(posedge clk) disable iff (sys_rst)
        state_q == USI_TX_STOP ##1 state_q == USI_TX_IDLE);

endmodule

// File: usi_status_irq.sv
/*
 * status flags, edge-detected interrupt logic, register port,
 * baud timing and transmit holding buffer of the serial transceiver.
 * assumes: receiver supplies one-cycle error and load pulses; inputs are
 * synchronous to clk; bus strobes are single cycles and never overlap.
 */
// Implementation choices: the register offsets and the address-and-strobe port.
// Behaviour
// - the written character's bit zero goes out first after the start bit
// - transmit parity settings are separate from receive parity settings
// - holding-empty pin tracks the holding buffer; its flag sets when the buffer loads the shifter
// - transmission complete only when holding buffer and shifter are empty
// - one control bit masks modem interrupts, another gates every interrupt
// - any level change on either modem input sets the modem change flag
// - a modem status read clears the change detector, not the live bits
// - modem status bits show the live inverted modem input levels
// - status edge detectors fire only on a flag's false to true change
// - a line status read clears flags and detectors, holding-empty and data-ready pins stay untouched
// - reset sets transmission complete and arms its edge detector
// - no status bit sets during a status read; it sets after the strobe
// - a set bit recurring during its read ends cleared after the strobe
// - baud divider is exact when fed the nominal reference frequency
// - with the global enable false the interrupt output stays low
// - holding-empty and data-ready never contribute to the interrupt
`timescale 1ns/1ps
`include "usi_regs.svh"

module usi_status_irq
    import usi_pkg::*;
#(
    parameter int ACC_W = 26
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [3:0]   addr,
    input  wire usi_byte_type wr_data,
    input  wire logic         wr_stb,
    input  wire logic         rd_stb,
    output usi_byte_type      rd_data,
    input  wire logic         cts_n,
    input  wire logic         dsr_n,
    input  wire logic         rx_load,
    input  wire usi_byte_type rx_data,
    input  wire logic         rx_overrun,
    input  wire logic         rx_parity_err,
    input  wire logic         rx_framing_err,
    input  wire logic         rx_break,
    output logic              rx_par_en,
    output logic              rx_par_odd,
    output logic              rts_n,
    output logic              dtr_n,
    output logic              sdo,
    output logic              tx_hold_empty,
    output logic              rx_data_ready,
    output logic              irq_out
);

    usi_byte_type char_format_q;
    usi_byte_type baud_select_q;
    usi_byte_type modem_control_q;
    usi_byte_type tx_hold_buffer_q;
    usi_byte_type rx_buffer_q;
    usi_byte_type lsr_q, lsr_d;
    usi_byte_type lsr_defer_q, lsr_defer_d;
    usi_byte_type ev;
    logic [5:0]   edge_q, edge_d;
    logic [5:0]   irq_mask_q;
    logic [5:0]   irq_enable_bits;
    logic [1:0]   modem_q;
    logic [1:0]   modem_now;
    logic         hold_full_q;
    logic         tx_busy;
    logic         tx_load;
    logic         done_lvl;
    logic         done_prev_q;
    logic         lsr_rd, msr_rd, any_rd;
    logic         wr_hit_irq;
    logic [ACC_W-1:0] acc_q;
    logic         ref_tick_q;
    logic [11:0]  bit_cnt_q;
    logic         bit_tick_q;

    assign lsr_rd     = rd_stb && addr == `USI_OFS_LINE_STAT;
    assign msr_rd     = rd_stb && addr == `USI_OFS_MODEM_STAT;
    assign any_rd     = lsr_rd || msr_rd;
    assign wr_hit_irq = wr_stb && addr == `USI_OFS_IRQ_STAT;
    assign modem_now  = ~{dsr_n, cts_n};
    assign done_lvl   = !hold_full_q && !tx_busy;
    assign tx_load    = hold_full_q && !tx_busy && !cts_n;

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            char_format_q   <= `USI_RST_CHAR_FMT;
            baud_select_q   <= `USI_RST_BAUD_SEL;
            modem_control_q <= `USI_RST_MODEM_CTL;
            irq_mask_q      <= `USI_RST_IRQ_MASK;
        end else if (wr_stb) begin
            unique case (addr)
                `USI_OFS_CHAR_FMT:  char_format_q   <= wr_data;
                `USI_OFS_BAUD_SEL:  baud_select_q   <= wr_data;
                `USI_OFS_MODEM_CTL: modem_control_q <= {1'b0, wr_data[6:0]};
                `USI_OFS_IRQ_MASK:  irq_mask_q      <= wr_data[5:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_par_en  <= 1'b0;
            rx_par_odd <= 1'b0;
            rts_n      <= 1'b1;
            dtr_n      <= 1'b1;
        end else begin
            rx_par_en  <= char_format_q[`USI_CF_RX_PAR_EN];
            rx_par_odd <= char_format_q[`USI_CF_RX_PAR_ODD];
            rts_n      <= !modem_control_q[`USI_MC_RTS];
            dtr_n      <= !modem_control_q[`USI_MC_DTR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference tick from fractional accumulator
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_q      <= '0;
            ref_tick_q <= 1'b0;
        end else if (acc_q + ACC_W'(`USI_REF_HZ) >= ACC_W'(`USI_CLK_HZ)) begin
            acc_q      <= acc_q + ACC_W'(`USI_REF_HZ) - ACC_W'(`USI_CLK_HZ);
            ref_tick_q <= 1'b1;
        end else begin
            acc_q      <= acc_q + ACC_W'(`USI_REF_HZ);
            ref_tick_q <= 1'b0;
        end
    end

    // bit time is divisor times oversample
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt_q  <= 12'h000;
            bit_tick_q <= 1'b0;
        end else begin
            bit_tick_q <= 1'b0;
            if (ref_tick_q) begin
                if (bit_cnt_q + 12'h001 >= {baud_select_q, 4'h0}) begin
                    bit_cnt_q  <= 12'h000;
                    bit_tick_q <= 1'b1;
                end else begin
                    bit_cnt_q <= bit_cnt_q + 12'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // holding buffer and transmitter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_hold_buffer_q <= 8'h00;
            hold_full_q      <= 1'b0;
        end else if (wr_stb && addr == `USI_OFS_TX_HOLD) begin
            tx_hold_buffer_q <= wr_data;
            hold_full_q      <= 1'b1;
        end else if (tx_load) begin
            hold_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_hold_empty <= 1'b1;
            done_prev_q   <= 1'b1;
        end else begin
            tx_hold_empty <= !hold_full_q;
            done_prev_q   <= done_lvl;
        end
    end

    usi_tx_shift u_tx (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .bit_tick  (bit_tick_q),
        .load      (tx_load),
        .load_data (tx_hold_buffer_q),
        .word_len  (char_format_q[`USI_CF_WLEN_HI:`USI_CF_WLEN_LO]),
        .stop2     (char_format_q[`USI_CF_STOP2]),
        .par_en    (char_format_q[`USI_CF_TX_PAR_EN]),
        .par_odd   (char_format_q[`USI_CF_TX_PAR_ODD]),
        .sdo       (sdo),
        .busy      (tx_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // receive buffer and data-ready pin, set wins over the clearing read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_buffer_q   <= 8'h00;
            rx_data_ready <= 1'b0;
        end else if (rx_load) begin
            rx_buffer_q   <= rx_data;
            rx_data_ready <= 1'b1;
        end else if (rd_stb && addr == `USI_OFS_RX_BUF) begin
            rx_data_ready <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modem input change, tracked through reset so release shows no change
    always_ff @(posedge clk) begin
        modem_q <= modem_now;
    end

    always_comb begin
        ev = 8'h00;
        ev[`USI_LS_OVERRUN] = rx_overrun;
        ev[`USI_LS_PARITY]  = rx_parity_err;
        ev[`USI_LS_FRAMING] = rx_framing_err;
        ev[`USI_LS_BREAK]   = rx_break;
        ev[`USI_LS_MODEM]   = modem_now != modem_q;
        ev[`USI_LS_TXDONE]  = done_lvl && !done_prev_q;
        ev[`USI_LS_TXEMPTY] = tx_load;
        ev[`USI_LS_RXRDY]   = rx_load;
    end

    // sets held off during a status read
    // line status read clears all flags
    // modem status read clears the change flag
    always_comb begin
        lsr_d       = lsr_q | ev | lsr_defer_q;
        lsr_defer_d = 8'h00;
        if (lsr_rd) begin
            lsr_d       = 8'h00;
            lsr_defer_d = (ev & ~lsr_q) | lsr_defer_q;
        end else if (msr_rd) begin
            lsr_d = lsr_q;
            lsr_d[`USI_LS_MODEM] = 1'b0;
            lsr_defer_d = (ev & ~lsr_q) | lsr_defer_q;
        end
    end

    // edge on false to true only
    // only low six flags have detectors
    always_comb begin
        edge_d = edge_q | (lsr_d[5:0] & ~lsr_q[5:0]);
        if (lsr_rd) begin
            edge_d = 6'h00;
        end else if (msr_rd) begin
            edge_d = edge_q & ~`USI_EDGE_MODEM_MASK;
        end else if (wr_hit_irq) begin
            edge_d = (edge_q & ~wr_data[5:0]) | (lsr_d[5:0] & ~lsr_q[5:0]);
        end
    end

    // reset sets done flag and its edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lsr_q       <= `USI_RST_LINE_STAT;
            lsr_defer_q <= 8'h00;
            edge_q      <= `USI_RST_EDGE;
        end else begin
            lsr_q       <= lsr_d;
            lsr_defer_q <= lsr_defer_d;
            edge_q      <= edge_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modem mask on its detector
    assign irq_enable_bits = irq_mask_q & ~(modem_control_q[`USI_MC_MODEM_IRQ_MASK] ? 6'h00
                                                          : `USI_EDGE_MODEM_MASK);

    // global gate, or of armed detectors
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= modem_control_q[`USI_MC_GLOBAL_IRQ_ENABLE] && |(edge_q & irq_enable_bits);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (rd_stb) begin
            unique case (addr)
                `USI_OFS_CHAR_FMT:   rd_data <= char_format_q;
                `USI_OFS_BAUD_SEL:   rd_data <= baud_select_q;
                `USI_OFS_MODEM_CTL:  rd_data <= modem_control_q;
                `USI_OFS_LINE_STAT:  rd_data <= lsr_q;
                `USI_OFS_MODEM_STAT: rd_data <= {6'h00, modem_now};
                `USI_OFS_RX_BUF:     rd_data <= rx_buffer_q;
                `USI_OFS_IRQ_STAT:   rd_data <= {2'b00, edge_q};
                `USI_OFS_IRQ_MASK:   rd_data <= {2'b00, irq_mask_q};
                default:             rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    hold_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 tx_hold_empty == !$past(hold_full_q))
        else $error("holding empty pin does not track buffer");

    txdone_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(lsr_q[`USI_LS_TXDONE]) |-> $past(!hold_full_q && !tx_busy))
        else $error("done event with data still pending");

    irq_modem_irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!modem_control_q[`USI_MC_MODEM_IRQ_MASK] && (edge_q & ~`USI_EDGE_MODEM_MASK) == 6'h00)
        |=> !irq_out)
        else $error("masked modem change raised irq");

    modem_change_a: assert property (@(posedge clk) disable iff (sys_rst)
        (modem_now != modem_q && !any_rd) |=> lsr_q[`USI_LS_MODEM])
        else $error("modem change not flagged");

    msr_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        msr_rd |=> !lsr_q[`USI_LS_MODEM] && !edge_q[`USI_LS_MODEM])
        else $error("modem status read left detector set");

    msr_live_a: assert property (@(posedge clk) disable iff (sys_rst)
        msr_rd |=> rd_data[1:0] == ~$past({dsr_n, cts_n}))
        else $error("modem status not live inverted pins");

    rise_only_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 ((edge_q & ~$past(edge_q)) & ~(lsr_q[5:0] & ~$past(lsr_q[5:0]))) == 6'h00)
        else $error("edge latch set without flag rising");

    lsr_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        lsr_rd |=> lsr_q == 8'h00 && edge_q == 6'h00)
        else $error("line status read did not clear");

    pin_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        (lsr_rd && !rx_load) |=> rx_data_ready == $past(rx_data_ready))
        else $error("line status read disturbed data-ready pin");

    reset_tc_a: assert property (@(posedge clk)
        $fell(sys_rst) |-> lsr_q[`USI_LS_TXDONE] && edge_q[`USI_LS_TXDONE])
        else $error("reset did not arm transmission complete");

    read_inhibit_a: assert property (@(posedge clk) disable iff (sys_rst)
        any_rd |=> (lsr_q & ~$past(lsr_q)) == 8'h00)
        else $error("status bit set during read");

    defer_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        (lsr_rd && ev[`USI_LS_OVERRUN] && !lsr_q[`USI_LS_OVERRUN]) ##1 !any_rd
        |=> lsr_q[`USI_LS_OVERRUN])
        else $error("deferred status bit lost");

    recur_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (lsr_rd && ev[`USI_LS_OVERRUN] && lsr_q[`USI_LS_OVERRUN]) ##1 !ev[`USI_LS_OVERRUN]
        |=> !lsr_q[`USI_LS_OVERRUN])
        else $error("recurring set bit set again after read");

    irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !modem_control_q[`USI_MC_GLOBAL_IRQ_ENABLE] |=> !irq_out)
        else $error("irq high with global enable off");

    irq_or_a: assert property (@(posedge clk) disable iff (sys_rst)
        (modem_control_q[`USI_MC_GLOBAL_IRQ_ENABLE] && (edge_q & irq_enable_bits) != 6'h00) |=> irq_out)
        else $error("armed detector did not raise irq");

    irq_rise_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq_out));

    defer_c: cover property (@(posedge clk) disable iff (sys_rst)
        lsr_rd && ev[`USI_LS_MODEM] ##1 lsr_defer_q[`USI_LS_MODEM]);

    irq_drop_c: cover property (@(posedge clk) disable iff (sys_rst)
        irq_out ##1 lsr_rd ##2 !irq_out);

endmodule

// File: usi_far_model.sv
/* far side model: receiver event pulses and the two modem pins.
   assumes: the bench raises ev and tog for one cycle at a time. */
`timescale 1ns/1ps
module usi_far_model
    import usi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [4:0] ev,
    input  wire logic [1:0] tog,
    output logic [4:0]      pulse,
    output usi_byte_type    rx_char,
    output logic            cts_n,
    output logic            dsr_n
);
    assign pulse = ev;
    assign rx_char = 8'hA5;
    initial begin
        cts_n = 1'b0;
        dsr_n = 1'b1;
    end
    // pins only move on request, so every change is a real event
    always @(posedge clk) begin
        if (tog[0]) cts_n <= ~cts_n;
        if (tog[1]) dsr_n <= ~dsr_n;
    end
endmodule

// File: uart_status_interrupt_logic_bench.sv
/* bench: register port tasks and check sequences for usi_status_irq.
   assumes: usi_far_model supplies receiver events and modem pins. */
`timescale 1ns/1ps
module uart_status_interrupt_logic_bench
    import usi_pkg::*;
;
    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic [3:0]   addr = 4'h0;
    usi_byte_type wr_data = 8'h00;
    logic         wr_stb = 1'b0;
    logic         rd_stb = 1'b0;
    logic [4:0]   ev = 5'h00;
    logic [1:0]   tog = 2'b00;
    usi_byte_type rd_data, rx_char;
    logic [4:0]   pulse;
    logic         cts_n, dsr_n, par_en, sdo, thre, rdy, irq;
    logic         par_odd, rts_n, dtr_n;
    int           err_count = 0;
    int           checks_done = 0;
    always #12.5 clk = ~clk;
    usi_status_irq uut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .cts_n(cts_n), .dsr_n(dsr_n), .rx_load(pulse[4]), .rx_data(rx_char),
        .rx_overrun(pulse[0]), .rx_parity_err(pulse[1]),
        .rx_framing_err(pulse[2]), .rx_break(pulse[3]), .rx_par_en(par_en),
        .rx_par_odd(par_odd), .rts_n(rts_n), .dtr_n(dtr_n), .sdo(sdo), .tx_hold_empty(thre),
        .rx_data_ready(rdy), .irq_out(irq));
    usi_far_model far (.clk(clk), .ev(ev), .tog(tog), .pulse(pulse),
        .rx_char(rx_char), .cts_n(cts_n), .dsr_n(dsr_n));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ev rides along so an event can share the strobe cycle
    task automatic rd(input logic [3:0] a, input logic [4:0] e, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        ev <= e;
        @(posedge clk);
        rd_stb <= 1'b0;
        ev <= 5'h00;
        #1 chk("rd_data", rd_data, x);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic kick(input logic [4:0] e, input logic [1:0] t);
        @(posedge clk);
        ev <= e;
        tog <= t;
        @(posedge clk);
        ev <= 5'h00;
        tog <= 2'b00;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #500000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(4'h7, 5'h00, 8'h20);
        rd(4'h3, 5'h00, 8'h60);
        rd(4'h7, 5'h00, 8'h00);
        rd(4'h9, 5'h00, 8'h00);
        wr(4'h2, 8'h40);
        kick(5'h00, 2'b00);
        chk("irq", irq, 8'h00);
        for (int i = 0; i < 4; i++) begin
            kick(5'h01 << i, 2'b00);
            chk("irq", irq, 8'h01);
            rd(4'h3, 5'h00, 8'h01 << i);
        end
        kick(5'h00, 2'b00);
        chk("irq", irq, 8'h00);
        rd(4'h3, 5'h01, 8'h00);
        rd(4'h3, 5'h01, 8'h01);
        rd(4'h3, 5'h00, 8'h00);
        wr(4'h2, 8'h00);
        kick(5'h02, 2'b00);
        chk("irq", irq, 8'h00);
        rd(4'h3, 5'h00, 8'h02);
        wr(4'h2, 8'h40);
        kick(5'h10, 2'b00);
        chk("irq", irq, 8'h00);
        rd(4'h3, 5'h00, 8'h80);
        chk("rdy", rdy, 8'h01);
        rd(4'h6, 5'h00, 8'hA5);
        @(posedge clk);
        #1 chk("rdy", rdy, 8'h00);
        kick(5'h00, 2'b10);
        chk("irq", irq, 8'h00);
        rd(4'h4, 5'h00, 8'h03);
        rd(4'h3, 5'h00, 8'h00);
        wr(4'h2, 8'h60);
        kick(5'h00, 2'b01);
        chk("irq", irq, 8'h01);
        rd(4'h4, 5'h00, 8'h02);
        kick(5'h00, 2'b01);
        chk("irq", irq, 8'h01);
        rd(4'h3, 5'h00, 8'h10);
        wr(4'h0, 8'h63);
        wr(4'h1, 8'h01);
        wr(4'h2, 8'h03);
        rd(4'h3, 5'h00, 8'h00);
        rd(4'h6, 5'h00, 8'hA5);
        chk("par_en", par_en, 8'h01);
        chk("par_odd", par_odd, 8'h01);
        chk("rts_n", rts_n, 8'h00);
        chk("dtr_n", dtr_n, 8'h00);
        wr(4'h5, 8'h96);
        for (int i = 0; i < 3000 && sdo !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        rd(4'h3, 5'h00, 8'h40);
        repeat (128) @(posedge clk);
        chk("sdo", sdo, 8'h00);
        for (int i = 0; i < 10; i++) begin
            repeat (260) @(posedge clk);
            chk("sdo", sdo, i < 8 ? (8'h96 >> i) & 8'h01 : 8'h01);
        end
        repeat (200) @(posedge clk);
        chk("thre", thre, 8'h01);
        rd(4'h3, 5'h00, 8'h20);
        test_done();
    end
endmodule
